// *** verilog/addressing_cycle_sequencer.sv ***
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Exactly one memory read or write every clock cycle.
// (RQ2) Effective address is high byte above low byte, sixteen bits.
// (RQ3) First cycle drives PC, reads opcode, increments PC.
// (RQ4) Opcode fetch increment lands in that same cycle.
// (RQ5) Absolute cycle two reads low byte while decoding, advances PC.
// (RQ6) Low byte held while cycle three reads high byte, advances PC.
// (RQ7) Absolute bytes ordered opcode, low byte, high byte.
// (RQ8) Absolute cycle four drives effective address, captures operand, PC unchanged.
// (RQ9) Next opcode fetched while previous arithmetic still computing.
// (RQ10) Following cycle writes result to accumulator while decoding next instruction.
// (RQ11) Every instruction takes at least two cycles.
// (RQ12) Implied instruction is one opcode byte on internal state.
// (RQ13) Non-stack implied instructions take two cycles.
// (RQ14) Implied cycle two reads incremented PC, discards byte, no increment.
// (RQ15) Same address fetched again as next opcode, now incrementing.
// (RQ16) Two-cycle implied group: flags, index steps, transfers, no-op.
// (RQ17) Stack implied operations take more than two cycles.
// (RQ18) Immediate is two bytes; operand in cycle two, next opcode cycle three.
// (RQ19) Write asserted only when a store moves data to the effective address.
module addressing_cycle_sequencer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  mem_rdata,
  output logic      [15:0] mem_addr,
  output logic             mem_write,
  output logic      [7:0]  mem_wdata,
  output logic             opcode_fetch,
  output logic      [7:0]  acc,
  output logic      [7:0]  index_x,
  output logic             carry_flag
);
  // Bus cycle currently being issued
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_DEC   = 3'b001,
    ST_HIGH  = 3'b010,
    ST_DATA  = 3'b011,
    ST_STACK = 3'b100
  } state_t;

  state_t             state_r;
  state_t             state_nxt;
  logic [15:0]        pc_r;
  logic [15:0]        pc_nxt;
  logic [7:0]         opcode_r;
  logic [7:0]         address_low_byte_r;
  logic [7:0]         acc_r;
  logic [7:0]         x_r;
  logic               c_r;
  logic [8:0]         sum_r;
  seq_pkg::alu_op_t   pend_op_r;
  logic               pend_valid_r;
  logic [7:0]         pend_data_r;
  logic [1:0]         stack_cnt_r;
  seq_pkg::decode_t   dec;
  seq_pkg::bus_cycle_t bus_r;
  seq_pkg::bus_cycle_t bus_nxt;
  logic               fetch_r;

  opcode_decoder u_dec (
    .opcode (opcode_r),
    .dec    (dec)
  );

  // Address assembly for the bus request; the checks concatenate their own
  function automatic logic [15:0] join_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] a;
    a = 16'h0000;
    a[seq_pkg::ADDRESS_HIGH_BYTE_LSB +: 8] = hi;
    a[seq_pkg::ADDRESS_LOW_BYTE_LSB +: 8]  = lo;
    return a;
  endfunction

  // Opcode register: captured on every fetch cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcode_r <= seq_pkg::OPC_NOP;
    end else if (state_r == ST_FETCH) begin
      opcode_r <= mem_rdata;
    end
  end

  // Next state and PC; bus always issues one access
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    bus_nxt   = '{addr: pc_r, write: 1'b0, wdata: acc_r};
    unique case (state_r)
      // (RQ3) fetch and increment
      // (RQ15) refetch now increments
      ST_FETCH: begin
        pc_nxt    = pc_r + 16'h0001;
        state_nxt = ST_DEC;
        bus_nxt.addr = pc_r + 16'h0001;
      end
      // (RQ14) implied and stack discard byte, no increment; immediate and absolute advance
      ST_DEC: begin
        unique case (dec.mode)
          // (RQ12) opcode-only instruction
          // (RQ13) back to fetch
          seq_pkg::MODE_IMPLIED: begin
            state_nxt = ST_FETCH;
          end
          // (RQ18) operand, then fetch
          seq_pkg::MODE_IMMEDIATE: begin
            pc_nxt    = pc_r + 16'h0001;
            state_nxt = ST_FETCH;
            bus_nxt.addr = pc_r + 16'h0001;
          end
          // (RQ5) low byte, advance
          seq_pkg::MODE_ABSOLUTE: begin
            pc_nxt    = pc_r + 16'h0001;
            state_nxt = ST_HIGH;
            bus_nxt.addr = pc_r + 16'h0001;
          end
          seq_pkg::MODE_STACK: begin
            state_nxt = ST_STACK;
          end
        endcase
      end
      // (RQ6) high byte cycle, advance; requests the effective address for the next cycle
      ST_HIGH: begin
        pc_nxt        = pc_r + 16'h0001;
        state_nxt     = ST_DATA;
        bus_nxt.addr  = join_addr(mem_rdata, address_low_byte_r);
        bus_nxt.write = (dec.op == seq_pkg::OP_STORE);
      end
      ST_DATA: begin
        state_nxt = ST_FETCH;
      end
      // (RQ17) stack ops keep reading the PC
      ST_STACK: begin
        if (stack_cnt_r == 2'(seq_pkg::STACK_EXTRA_CYCLES - 1)) begin
          state_nxt = ST_FETCH;
        end
      end
      default: begin
        state_nxt = ST_FETCH;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_FETCH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // (RQ4) PC updates within the cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= seq_pkg::PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // (RQ1) registered bus cycle each edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_r   <= '{addr: seq_pkg::PC_RESET, write: 1'b0, wdata: seq_pkg::ACC_RESET};
      fetch_r <= 1'b1;
    end else begin
      bus_r   <= bus_nxt;
      fetch_r <= (state_nxt == ST_FETCH);
    end
  end

  // (RQ6) hold low byte during high fetch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      address_low_byte_r <= 8'h00;
    end else if (state_r == ST_DEC && dec.mode == seq_pkg::MODE_ABSOLUTE) begin
      address_low_byte_r <= mem_rdata;
    end
  end

  // Stack cycle counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_cnt_r <= 2'b00;
    end else if (state_r == ST_STACK) begin
      stack_cnt_r <= stack_cnt_r + 2'b01;
    end else begin
      stack_cnt_r <= 2'b00;
    end
  end

  // (RQ9) operand latched; arithmetic finishes during next fetch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_valid_r <= 1'b0;
      pend_op_r    <= seq_pkg::OP_NONE;
      pend_data_r  <= 8'h00;
    end else begin
      pend_valid_r <= 1'b0;
      if ((state_r == ST_DEC && dec.mode == seq_pkg::MODE_IMMEDIATE) || state_r == ST_DATA) begin
        pend_valid_r <= (dec.op != seq_pkg::OP_STORE);
        pend_op_r    <= dec.op;
        pend_data_r  <= mem_rdata;
      end else if (state_r == ST_DEC && dec.mode == seq_pkg::MODE_IMPLIED) begin
        pend_valid_r <= 1'b1;
        pend_op_r    <= dec.op;
        pend_data_r  <= 8'h00;
      end
    end
  end

  // Add computed in the overlapped fetch cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sum_r <= 9'h000;
    end else begin
      sum_r <= {1'b0, acc_r} + {1'b0, pend_data_r} + {8'h00, c_r};
    end
  end

  // Result presence one cycle after compute
  logic             wb_valid_r;
  seq_pkg::alu_op_t wb_op_r;
  logic [7:0]       wb_data_r;
  logic [7:0]       wb_opc_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid_r <= 1'b0;
      wb_op_r    <= seq_pkg::OP_NONE;
      wb_data_r  <= 8'h00;
      wb_opc_r   <= seq_pkg::OPC_NOP;
    end else begin
      wb_valid_r <= pend_valid_r;
      wb_op_r    <= pend_op_r;
      wb_data_r  <= pend_data_r;
      wb_opc_r   <= opcode_r;
    end
  end

  // (RQ10) accumulator written in the decode of next instruction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= seq_pkg::ACC_RESET;
    end else if (wb_valid_r) begin
      unique case (wb_op_r)
        seq_pkg::OP_ADD:  acc_r <= sum_r[7:0];
        seq_pkg::OP_LOAD: acc_r <= wb_data_r;
        seq_pkg::OP_TXA:  acc_r <= x_r;
        default:          acc_r <= acc_r;
      endcase
    end
  end

  // (RQ16) index steps, transfers and flag ops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      x_r <= seq_pkg::IDX_RESET;
      c_r <= 1'b0;
    end else if (wb_valid_r) begin
      unique case (wb_op_r)
        seq_pkg::OP_INX: x_r <= x_r + 8'h01;
        seq_pkg::OP_DEX: x_r <= x_r - 8'h01;
        seq_pkg::OP_TAX: x_r <= acc_r;
        default:         x_r <= x_r;
      endcase
      if (wb_op_r == seq_pkg::OP_ADD) begin
        c_r <= sum_r[8];
      end else if (wb_opc_r == seq_pkg::OPC_CLC) begin
        c_r <= 1'b0;
      end else if (wb_opc_r == seq_pkg::OPC_SEC) begin
        c_r <= 1'b1;
      end
    end
  end

  assign mem_addr     = bus_r.addr;
  assign mem_write    = bus_r.write;
  assign mem_wdata    = bus_r.wdata;
  assign opcode_fetch = fetch_r;
  assign acc          = acc_r;
  assign index_x      = x_r;
  assign carry_flag   = c_r;

  // Checks
  property p_inc_on_fetch;
    @(posedge clk) disable iff (!rstn) state_r == ST_FETCH |=> pc_r == $past(pc_r) + 16'h0001;
  endproperty
  a_inc_on_fetch: assert property (p_inc_on_fetch) else $error("pc not incremented on fetch"); // RQ3
  property p_addr_is_pc;
    @(posedge clk) disable iff (!rstn) opcode_fetch |-> mem_addr == pc_r;
  endproperty
  a_addr_is_pc: assert property (p_addr_is_pc) else $error("fetch address not pc"); // RQ4
  property p_impl_hold;
    @(posedge clk) disable iff (!rstn)
      state_r == ST_DEC && dec.mode == seq_pkg::MODE_IMPLIED |=> pc_r == $past(pc_r) && state_r == ST_FETCH;
  endproperty
  a_impl_hold: assert property (p_impl_hold) else $error("implied decode moved pc"); // RQ14
  property p_abs_seq;
    @(posedge clk) disable iff (!rstn)
      state_r == ST_DEC && dec.mode == seq_pkg::MODE_ABSOLUTE |=> state_r == ST_HIGH ##1 state_r == ST_DATA;
  endproperty
  a_abs_seq: assert property (p_abs_seq) else $error("absolute sequence broken"); // RQ7
  property p_ea;
    @(posedge clk) disable iff (!rstn)
      state_r == ST_HIGH |=> mem_addr == {$past(mem_rdata), $past(address_low_byte_r)};
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong"); // RQ2
  property p_data_pc;
    @(posedge clk) disable iff (!rstn) state_r == ST_DATA |=> pc_r == $past(pc_r);
  endproperty
  a_data_pc: assert property (p_data_pc) else $error("pc moved in data cycle"); // RQ8
  property p_write_only_store;
    @(posedge clk) disable iff (!rstn) mem_write |-> state_r == ST_DATA && dec.op == seq_pkg::OP_STORE;
  endproperty
  a_write_only_store: assert property (p_write_only_store) else $error("stray write"); // RQ19
  property p_min_two;
    @(posedge clk) disable iff (!rstn) state_r == ST_FETCH |=> state_r != ST_FETCH;
  endproperty
  a_min_two: assert property (p_min_two) else $error("instruction shorter than two cycles"); // RQ11
  property p_stack_long;
    @(posedge clk) disable iff (!rstn)
      state_r == ST_DEC && dec.mode == seq_pkg::MODE_STACK |=> (state_r == ST_STACK)[*2];
  endproperty
  a_stack_long: assert property (p_stack_long) else $error("stack op too short"); // RQ17
endmodule

// *** inc/seq_pkg.sv ***
package seq_pkg;
  // Instruction length classes the decoder reports
  typedef enum logic [1:0] {
    MODE_IMPLIED   = 2'b00,
    MODE_IMMEDIATE = 2'b01,
    MODE_ABSOLUTE  = 2'b10,
    MODE_STACK     = 2'b11
  } addr_mode_t;

  // Internal register operation classes
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_ADD   = 3'b001,
    OP_LOAD  = 3'b010,
    OP_STORE = 3'b011,
    OP_INX   = 3'b100,
    OP_DEX   = 3'b101,
    OP_TAX   = 3'b110,
    OP_TXA   = 3'b111
  } alu_op_t;

  // Decoded instruction summary
  typedef struct packed {
    addr_mode_t mode;
    alu_op_t    op;
  } decode_t;

  // Memory bus cycle request
  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic [7:0]  wdata;
  } bus_cycle_t;

  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  ACC_RESET  = 8'h00;
  localparam logic [7:0]  IDX_RESET  = 8'h00;
  localparam int          ADDRESS_LOW_BYTE_LSB  = 0;
  localparam int          ADDRESS_HIGH_BYTE_LSB = 8;
  localparam int          STACK_EXTRA_CYCLES = 2;

  // Opcode codes, chosen encodings
  localparam logic [7:0] OPC_NOP     = 8'hEA;
  localparam logic [7:0] OPC_INX     = 8'hE8;
  localparam logic [7:0] OPC_DEX     = 8'hCA;
  localparam logic [7:0] OPC_TAX     = 8'hAA;
  localparam logic [7:0] OPC_TXA     = 8'h8A;
  localparam logic [7:0] OPC_CLC     = 8'h18;
  localparam logic [7:0] OPC_SEC     = 8'h38;
  localparam logic [7:0] OPC_ADD_IMM = 8'h69;
  localparam logic [7:0] OPC_LDA_IMM = 8'hA9;
  localparam logic [7:0] OPC_ADD_ABS = 8'h6D;
  localparam logic [7:0] OPC_LDA_ABS = 8'hAD;
  localparam logic [7:0] OPC_STORE_ACCUMULATOR_ABS = 8'h8D;
  localparam logic [7:0] OPC_PUSH    = 8'h48;
endpackage

// *** verilog/opcode_decoder.sv ***
`timescale 1ns/1ps
// Pure combinational opcode classifier
module opcode_decoder (
  input  wire logic [7:0]      opcode,
  output seq_pkg::decode_t     dec
);
  // Unknown codes fall back to a two-cycle no-op
  always_comb begin
    dec.mode = seq_pkg::MODE_IMPLIED;
    dec.op   = seq_pkg::OP_NONE;
    unique case (opcode)
      seq_pkg::OPC_INX:     dec.op = seq_pkg::OP_INX;
      seq_pkg::OPC_DEX:     dec.op = seq_pkg::OP_DEX;
      seq_pkg::OPC_TAX:     dec.op = seq_pkg::OP_TAX;
      seq_pkg::OPC_TXA:     dec.op = seq_pkg::OP_TXA;
      seq_pkg::OPC_ADD_IMM: begin
        dec.mode = seq_pkg::MODE_IMMEDIATE;
        dec.op   = seq_pkg::OP_ADD;
      end
      seq_pkg::OPC_LDA_IMM: begin
        dec.mode = seq_pkg::MODE_IMMEDIATE;
        dec.op   = seq_pkg::OP_LOAD;
      end
      seq_pkg::OPC_ADD_ABS: begin
        dec.mode = seq_pkg::MODE_ABSOLUTE;
        dec.op   = seq_pkg::OP_ADD;
      end
      seq_pkg::OPC_LDA_ABS: begin
        dec.mode = seq_pkg::MODE_ABSOLUTE;
        dec.op   = seq_pkg::OP_LOAD;
      end
      seq_pkg::OPC_STORE_ACCUMULATOR_ABS: begin
        dec.mode = seq_pkg::MODE_ABSOLUTE;
        dec.op   = seq_pkg::OP_STORE;
      end
      seq_pkg::OPC_PUSH:    dec.mode = seq_pkg::MODE_STACK;
      default: begin
        dec.mode = seq_pkg::MODE_IMPLIED;
        dec.op   = seq_pkg::OP_NONE;
      end
    endcase
  end
endmodule

// *** tb/mem_model.sv ***
`timescale 1ns/1ps
// Flat zero-wait memory behind the sequencer
module mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_write,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];

  // Unwritten space reads as no-op, so stray fetches stay defined
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hEA;
    end
  end

  // one access per cycle
  // Read answers within the cycle, no wait states
  assign mem_rdata = mem[mem_addr];

  // store data lands
  // Plain always, the bench also preloads this array
  always @(posedge clk) begin
    if (mem_write) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// *** tb/test_addressing_cycle_sequencer.sv ***
`timescale 1ns/1ps
// Cycle-exact trace bench for the bus-cycle sequencer
module test_addressing_cycle_sequencer;
  logic        clk;
  logic        rstn;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic        mem_write;
  logic [7:0]  mem_wdata;
  logic        opcode_fetch;
  logic [7:0]  acc;
  logic [7:0]  index_x;
  logic        carry_flag;
  int          bad_count;
  int          check_count;
  int          cycles;
  logic [15:0] pc;
  logic [7:0]  prog_q [$];

  addressing_cycle_sequencer dut_u (
    .clk          (clk),
    .rstn         (rstn),
    .mem_rdata    (mem_rdata),
    .mem_addr     (mem_addr),
    .mem_write    (mem_write),
    .mem_wdata    (mem_wdata),
    .opcode_fetch (opcode_fetch),
    .acc          (acc),
    .index_x      (index_x),
    .carry_flag   (carry_flag)
  );

  mem_model mem_u (
    .clk       (clk),
    .mem_addr  (mem_addr),
    .mem_write (mem_write),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus cycle, judged mid-cycle where outputs are settled
  task automatic step(input logic [15:0] a, input logic f, input logic w);
    @(negedge clk);
    check("mem_addr", mem_addr, a);
    check("opcode_fetch", {15'h0000, opcode_fetch}, {15'h0000, f});
    check("mem_write", {15'h0000, mem_write}, {15'h0000, w});
  endtask

  // Load program at 0000, then reset so the run starts there
  task automatic start;
    for (int i = 0; i < prog_q.size(); i++) begin
      mem_u.mem[i] = prog_q[i];
    end
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check("reset addr", mem_addr, seq_pkg::PC_RESET);
    check("reset acc", {8'h00, acc}, {8'h00, seq_pkg::ACC_RESET});
    check("reset x", {8'h00, index_x}, {8'h00, seq_pkg::IDX_RESET});
    check("reset carry", {15'h0000, carry_flag}, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    pc = seq_pkg::PC_RESET;
  endtask

  // two-cycle implied
  // Second cycle rereads pc+1, which is fetched again next
  task automatic t_impl;
    step(pc, 1'b1, 1'b0);
    step(pc + 16'h0001, 1'b0, 1'b0);
    pc = pc + 16'h0001;
  endtask

  task automatic t_imm;
    step(pc, 1'b1, 1'b0);
    step(pc + 16'h0001, 1'b0, 1'b0);
    pc = pc + 16'h0002;
  endtask

  task automatic t_abs(input logic [15:0] ea, input logic w);
    step(pc, 1'b1, 1'b0);
    step(pc + 16'h0001, 1'b0, 1'b0);
    step(pc + 16'h0002, 1'b0, 1'b0);
    step(ea, 1'b0, w);
    pc = pc + 16'h0003;
  endtask

  // Absolute add with overlapped completion
  task automatic s_absolute;
    prog_q = '{8'hA9, 8'h05, 8'h6D, 8'h34, 8'h12};
    mem_u.mem[16'h1234] = 8'h10;
    start();
    t_imm();
    t_abs(16'h1234, 1'b0);
    step(pc, 1'b1, 1'b0);
    check("acc in fetch", {8'h00, acc}, 16'h0005);
    step(pc + 16'h0001, 1'b0, 1'b0);
    step(pc + 16'h0001, 1'b1, 1'b0);
    check("acc sum", {8'h00, acc}, 16'h0015);
  endtask

  // Store then load back through the same place
  task automatic s_store_load;
    prog_q = '{8'hA9, 8'h5A, 8'h8D, 8'h00, 8'h02, 8'hA9, 8'h00, 8'hAD, 8'h00, 8'h02};
    start();
    t_imm();
    t_abs(16'h0200, 1'b1);
    check("mem_wdata", {8'h00, mem_wdata}, 16'h005A);
    t_imm();
    t_abs(16'h0200, 1'b0);
    t_impl();
    step(pc, 1'b1, 1'b0);
    check("acc load", {8'h00, acc}, 16'h005A);
    check("stored byte", {8'h00, mem_u.mem[16'h0200]}, 16'h005A);
  endtask

  // Every two-cycle implied code except NOP, plus an unknown one
  task automatic s_implied;
    prog_q = '{8'h18, 8'hA9, 8'h7F, 8'hE8, 8'hE8, 8'hCA, 8'hAA, 8'hCA, 8'h8A, 8'hFF, 8'h38, 8'h69, 8'h01,
               8'h38, 8'h18};
    start();
    t_impl();
    t_imm();
    repeat (8) t_impl();
    t_imm();
    t_impl();
    t_impl();
    check("index_x", {8'h00, index_x}, 16'h007E);
    check("acc add carry", {8'h00, acc}, 16'h0080);
    check("carry_flag", {15'h0000, carry_flag}, 16'h0000);
    // Trailing set then clear lands two cycles apart
    t_impl();
    check("carry set", {15'h0000, carry_flag}, 16'h0001);
    t_impl();
    check("carry clear", {15'h0000, carry_flag}, 16'h0000);
  endtask

  // stack op longer than two cycles
  task automatic s_stack;
    prog_q = '{8'h48};
    start();
    step(pc, 1'b1, 1'b0);
    repeat (3) step(pc + 16'h0001, 1'b0, 1'b0);
    step(pc + 16'h0001, 1'b1, 1'b0);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    pc = 16'h0000;
    repeat (10) @(posedge clk);
    s_absolute();
    s_store_load();
    s_implied();
    s_stack();
    report_and_stop();
  end
endmodule
